/* hw/smrl_ctrl.sv */
// What this block does
// - strap 11 or mode 011 selects copper/1000X auto
// - mode 101 copper only, 111 1000X only
// - strap 10 or mode 010 selects copper/serial-media auto
// - mode 101 copper only, 110 serial media only
// - gigabit media: host link plain, no replication
// - copper 100/10: repeat bytes 10/100 times
// - host link modified negotiation, PHY role, status
// - 1000X fiber runs standard negotiation
// - serial media: MAC role, replicate 1/10/100
// - strap 01 or mode 001: converter, gigabit only
// - converter advertises stored and MAC abilities only
// - converter passes copper partner abilities to MAC
// - 100FX mode: repeat each byte ten times
// - page0/1 bit14 host loop, page2 line loop
// - host loop bit shared by pages 0 and 1
// - host loop returns MAC data, media gets none
// - host loop copper: receiver off, link down, tx per AN/speed
// - copper tx: FLP, link pulses, 100TX idles or gigabit idles
// - host loop fiber: powered, sync reported, idles
// - loop or no link: speed from page2 bits
// - copper, fiber, host speeds from pages 0,1,2
// - mode 000 is 100FX only, 100 reserved
`include "smrl_cfg.svh"
module smrl_ctrl
  import smrl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [1:0]  media_strap,
  input  wire smrl_stat_t  stat,
  input  wire smrl_byte_t  mac_rx,
  input  wire smrl_byte_t  media_rx,
  output smrl_byte_t       mac_tx,
  output smrl_byte_t       media_tx,
  output logic             media_rx_ready,
  output logic             cu_rx_pwrdn,
  output smrl_cutx_t       cu_tx_kind,
  output logic             fib_pwr_up,
  output logic             fib_tx_idle,
  output logic             fib_sync_rpt,
  output logic             lineloop_cu,
  output logic             lineloop_fb,
  output logic [15:0]      host_cfg_word,
  output logic             host_an_std,
  output logic             host_an_on,
  output smrl_fan_t        fib_an_kind,
  output logic [3:0]       cu_adv_eff,
  output logic [1:0]       host_speed
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0]  strap_s1;
    logic [1:0]  strap_s2;
    logic [1:0]  strap_s3;
    logic [1:0]  cfg_cnt;
    logic        cfg_done;
    logic [2:0]  mode;
    logic        host_lb;
    logic        line_lb;
    logic        cu_an;
    logic [1:0]  cu_spd;
    logic        fb_an;
    logic [1:0]  fb_spd;
    logic        host_an;
    logic [1:0]  host_spd;
    logic [3:0]  adv;
    logic        act;
    logic        wr;
    logic [7:0]  addr;
    logic        rdy;
    logic [31:0] rdata;
    logic [6:0]  dcnt;
    logic [6:0]  rcnt;
    smrl_byte_t  mac_tx;
    smrl_byte_t  media_tx;
    logic        rx_rdy;
    logic        cu_pd;
    smrl_cutx_t  cu_kind;
    logic        fib_pwr;
    logic        fib_idle;
    logic        fib_sync;
    logic        ll_cu;
    logic        ll_fb;
    logic [15:0] cfg_word;
    logic        an_std;
    smrl_fan_t   fan;
    logic [3:0]  adv_eff;
    logic [1:0]  speed;
    smrl_media_t med;
  } smrl_state_t;

  smrl_state_t q;
  smrl_state_t n;

  // ************************************************************
  // helpers
  // ************************************************************
  // {msb, lsb} speed bits; the unused code 11 falls back to gigabit
  function automatic logic [1:0] spd_of(input logic msb, input logic lsb);
    logic [1:0] s;
    s = {msb, lsb};
    if (s == 2'h3) begin
      s = `SMRL_SPD_1000;
    end
    return s;
  endfunction : spd_of

  function automatic logic [6:0] rep_of(input logic [1:0] spd);
    logic [6:0] r;
    r = `SMRL_REP_1;
    if (spd == `SMRL_SPD_100) begin
      r = `SMRL_REP_10;
    end else if (spd == `SMRL_SPD_10) begin
      r = `SMRL_REP_100;
    end
    return r;
  endfunction : rep_of

  function automatic logic [31:0] ctrl_word(input logic lb, input logic an, input logic [1:0] spd);
    logic [31:0] w;
    w = 32'h0;
    w[`SMRL_B_LB]      = lb;
    w[`SMRL_B_AN]      = an;
    w[`SMRL_B_SPD_MSB] = spd[1];
    w[`SMRL_B_SPD_LSB] = spd[0];
    return w;
  endfunction : ctrl_word

  // ************************************************************
  // next state
  // ************************************************************
  smrl_mode_t  mode;
  smrl_media_t med;
  logic        cu_mode;
  logic        fib_mode;
  logic        cu_link_eff;
  logic [1:0]  spd;
  logic [6:0]  rep;

  always_comb begin
    n = q;

    // strap pin: three stages, taken once stages two and three agree
    n.strap_s1 = media_strap;
    n.strap_s2 = q.strap_s1;
    n.strap_s3 = q.strap_s2;
    if (q.cfg_cnt != `SMRL_STRAP_WAIT) begin
      n.cfg_cnt = q.cfg_cnt + 2'h1;
    end else if (!q.cfg_done && q.strap_s2 == q.strap_s3) begin
      n.mode     = {1'b0, q.strap_s3};
      n.cfg_done = 1'b1;
    end

    // bus: reads take one wait state so read data is always current
    n.act = 1'b0;
    if (q.act && q.wr) begin
      if (q.addr == `SMRL_OFF_MODE) begin
        n.mode = hwdata[2:0];
      end else if (q.addr == `SMRL_OFF_CU) begin
        n.host_lb = hwdata[`SMRL_B_LB];
        n.cu_an   = hwdata[`SMRL_B_AN];
        n.cu_spd  = {hwdata[`SMRL_B_SPD_MSB], hwdata[`SMRL_B_SPD_LSB]};
      end else if (q.addr == `SMRL_OFF_FB) begin
        n.host_lb = hwdata[`SMRL_B_LB];
        n.fb_an   = hwdata[`SMRL_B_AN];
        n.fb_spd  = {hwdata[`SMRL_B_SPD_MSB], hwdata[`SMRL_B_SPD_LSB]};
      end else if (q.addr == `SMRL_OFF_HOST) begin
        n.line_lb  = hwdata[`SMRL_B_LB];
        n.host_an  = hwdata[`SMRL_B_AN];
        n.host_spd = {hwdata[`SMRL_B_SPD_MSB], hwdata[`SMRL_B_SPD_LSB]};
      end else if (q.addr == `SMRL_OFF_ADV) begin
        n.adv = hwdata[3:0];
      end
    end
    if (q.act && !q.wr) begin
      n.rdy = 1'b1;
      if (q.addr == `SMRL_OFF_MODE) begin
        n.rdata = {29'h0, q.mode};
      end else if (q.addr == `SMRL_OFF_CU) begin
        n.rdata = ctrl_word(q.host_lb, q.cu_an, q.cu_spd);
      end else if (q.addr == `SMRL_OFF_FB) begin
        n.rdata = ctrl_word(q.host_lb, q.fb_an, q.fb_spd);
      end else if (q.addr == `SMRL_OFF_HOST) begin
        n.rdata = ctrl_word(q.line_lb, q.host_an, q.host_spd);
      end else if (q.addr == `SMRL_OFF_ADV) begin
        n.rdata = {28'h0, q.adv};
      end else if (q.addr == `SMRL_OFF_STAT) begin
        n.rdata = {20'h0, q.ll_fb, q.ll_cu, q.cfg_done, q.cfg_word[`SMRL_SG_LINK], q.speed, q.med, q.mode};
      end else begin
        n.rdata = 32'h0;
      end
    end
    if (hready && hsel && htrans[1]) begin
      n.act  = 1'b1;
      n.wr   = hwrite;
      n.addr = haddr[7:0];
      if (!hwrite) begin
        n.rdy = 1'b0;
      end
    end

    // media family of the selected mode
    mode     = smrl_mode_t'(q.mode);
    cu_mode  = (mode == SMRL_M_GBIC) || (mode == SMRL_M_AUTO_SM) || (mode == SMRL_M_AUTO_X) || (mode == SMRL_M_CU);
    fib_mode = (mode != SMRL_M_GBIC) && (mode != SMRL_M_CU) && (mode != SMRL_M_RSVD);
    cu_link_eff = stat.cu_link && !q.host_lb;

    // auto modes prefer copper when both sides show link
    med = SMRL_MED_NONE;
    case (mode)
      SMRL_M_FX100:   med = stat.fx_link ? SMRL_MED_FX : SMRL_MED_NONE;
      SMRL_M_GBIC:    med = cu_link_eff ? SMRL_MED_CU : SMRL_MED_NONE;
      SMRL_M_AUTO_SM: med = cu_link_eff ? SMRL_MED_CU : (stat.sm_link ? SMRL_MED_SM : SMRL_MED_NONE);
      SMRL_M_AUTO_X:  med = cu_link_eff ? SMRL_MED_CU : (stat.x_link ? SMRL_MED_X : SMRL_MED_NONE);
      SMRL_M_CU:      med = cu_link_eff ? SMRL_MED_CU : SMRL_MED_NONE;
      SMRL_M_SM:      med = stat.sm_link ? SMRL_MED_SM : SMRL_MED_NONE;
      SMRL_M_X:       med = stat.x_link ? SMRL_MED_X : SMRL_MED_NONE;
      default:        med = SMRL_MED_NONE;
    endcase
    if (q.host_lb) begin
      med = SMRL_MED_NONE;
    end
    n.med = med;

    // host link speed
    spd = spd_of(q.host_spd[1], q.host_spd[0]);
    case (med)
      SMRL_MED_CU: spd = (mode == SMRL_M_GBIC) ? `SMRL_SPD_1000 : stat.cu_speed;
      SMRL_MED_X:  spd = `SMRL_SPD_1000;
      SMRL_MED_FX: spd = `SMRL_SPD_100;
      SMRL_MED_SM: spd = q.fb_an ? stat.sm_speed : spd_of(q.fb_spd[1], q.fb_spd[0]);
      default:     spd = spd_of(q.host_spd[1], q.host_spd[0]);
    endcase
    n.speed = spd;
    rep     = rep_of(spd);

    // MAC to media: keep first byte of each group, gap realigns
    n.media_tx = '0;
    n.mac_tx   = '0;
    if (!mac_rx.valid) begin
      n.dcnt = 7'h0;
    end else if (q.dcnt == rep - 7'h1) begin
      n.dcnt = 7'h0;
    end else begin
      n.dcnt = q.dcnt + 7'h1;
    end
    if (q.host_lb) begin
      n.mac_tx = mac_rx;
      n.rcnt   = 7'h0;
    end else begin
      if (mac_rx.valid && q.dcnt == 7'h0) begin
        n.media_tx = mac_rx;
      end
      // media to MAC: hold each byte for the replication count
      if (q.rcnt != 7'h0) begin
        n.rcnt   = q.rcnt - 7'h1;
        n.mac_tx = q.mac_tx;
      end else if (media_rx.valid && q.rx_rdy) begin
        n.rcnt   = rep - 7'h1;
        n.mac_tx = media_rx;
      end
    end
    // no buffer: source stalls while a byte is still being repeated
    n.rx_rdy = (n.rcnt == 7'h0) && !q.host_lb;

    // media side behaviour during host loopback
    n.cu_pd   = q.host_lb && cu_mode;
    n.cu_kind = SMRL_CT_NORMAL;
    if (q.host_lb && cu_mode) begin
      if (q.cu_an) begin
        n.cu_kind = SMRL_CT_FLP;
      end else if (spd_of(q.cu_spd[1], q.cu_spd[0]) == `SMRL_SPD_10) begin
        n.cu_kind = SMRL_CT_LINK_PULSE;
      end else if (spd_of(q.cu_spd[1], q.cu_spd[0]) == `SMRL_SPD_100) begin
        n.cu_kind = SMRL_CT_IDLE100;
      end else begin
        n.cu_kind = SMRL_CT_IDLE1000;
      end
    end
    n.fib_pwr  = fib_mode;
    n.fib_idle = q.host_lb && fib_mode;
    n.fib_sync = stat.fib_sync && fib_mode;

    // line loopback only on the media that has link
    n.ll_cu = q.line_lb && (med == SMRL_MED_CU);
    n.ll_fb = q.line_lb && (med == SMRL_MED_X || med == SMRL_MED_SM || med == SMRL_MED_FX);

    // negotiation flavours
    n.fan = SMRL_FAN_OFF;
    if (mode == SMRL_M_AUTO_X || mode == SMRL_M_X) begin
      n.fan = SMRL_FAN_STD;
    end else if (mode == SMRL_M_AUTO_SM || mode == SMRL_M_SM) begin
      n.fan = SMRL_FAN_MAC_ROLE;
    end
    n.an_std  = (mode == SMRL_M_GBIC);
    // stored advertisement stays untouched; only the line copy is trimmed
    n.adv_eff = n.an_std ? (q.adv & stat.mac_abil) : q.adv;
    n.cfg_word = 16'h0;
    if (n.an_std) begin
      if (stat.cu_an_done && cu_link_eff) begin
        n.cfg_word[`SMRL_BX_FD +: 2]    = stat.cu_partner[1:0];
        n.cfg_word[`SMRL_BX_PAUSE +: 2] = stat.cu_partner[3:2];
      end
    end else begin
      n.cfg_word[`SMRL_SG_FIXED]    = 1'b1;
      n.cfg_word[`SMRL_SG_LINK]     = (med != SMRL_MED_NONE);
      n.cfg_word[`SMRL_SG_SPD +: 2] = spd;
      n.cfg_word[`SMRL_SG_FD]       = (med == SMRL_MED_CU) ? stat.cu_fd :
                                      (med == SMRL_MED_SM) ? stat.sm_fd : 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q          <= '0;
      q.mode     <= `SMRL_MODE_RST;
      q.cu_an    <= `SMRL_AN_RST;
      q.fb_an    <= `SMRL_AN_RST;
      q.host_an  <= `SMRL_AN_RST;
      q.cu_spd   <= `SMRL_SPD_RST;
      q.fb_spd   <= `SMRL_SPD_RST;
      q.host_spd <= `SMRL_SPD_RST;
      q.adv      <= `SMRL_ADV_RST;
      q.rdy      <= 1'b1;
      q.rx_rdy   <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hreadyout      = q.rdy;
  assign hrdata         = q.rdata;
  assign hresp          = q.act & 1'b0;
  assign mac_tx         = q.mac_tx;
  assign media_tx       = q.media_tx;
  assign media_rx_ready = q.rx_rdy;
  assign cu_rx_pwrdn    = q.cu_pd;
  assign cu_tx_kind     = q.cu_kind;
  assign fib_pwr_up     = q.fib_pwr;
  assign fib_tx_idle    = q.fib_idle;
  assign fib_sync_rpt   = q.fib_sync;
  assign lineloop_cu    = q.ll_cu;
  assign lineloop_fb    = q.ll_fb;
  assign host_cfg_word  = q.cfg_word;
  assign host_an_std    = q.an_std;
  assign host_an_on     = q.host_an;
  assign fib_an_kind    = q.fan;
  assign cu_adv_eff     = q.adv_eff;
  assign host_speed     = q.speed;

endmodule : smrl_ctrl

/* hw/smrl_cfg.svh */
`ifndef SMRL_CFG_SVH
`define SMRL_CFG_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define SMRL_OFF_MODE    8'h00
`define SMRL_OFF_CU      8'h04
`define SMRL_OFF_FB      8'h08
`define SMRL_OFF_HOST    8'h0c
`define SMRL_OFF_ADV     8'h10
`define SMRL_OFF_STAT    8'h14
// ************************************************************
// control word fields (same layout on all three pages)
// ************************************************************
`define SMRL_B_LB        14
`define SMRL_B_SPD_LSB   13
`define SMRL_B_AN        12
`define SMRL_B_SPD_MSB   6
`define SMRL_AN_RST      1'b1
`define SMRL_SPD_RST     2'h2
`define SMRL_ADV_RST     4'hf
`define SMRL_MODE_RST    3'h0
// ************************************************************
// speed codes, replication and host negotiation word
// ************************************************************
`define SMRL_SPD_10      2'h0
`define SMRL_SPD_100     2'h1
`define SMRL_SPD_1000    2'h2
`define SMRL_REP_1       7'h01
`define SMRL_REP_10      7'h0a
`define SMRL_REP_100     7'h64
`define SMRL_SG_LINK     15
`define SMRL_SG_FD       12
`define SMRL_SG_SPD      10
`define SMRL_SG_FIXED    0
`define SMRL_BX_FD       5
`define SMRL_BX_PAUSE    7
`define SMRL_STRAP_WAIT  2'h3
`endif

/* hw/smrl_pkg.sv */
package smrl_pkg;
  // field order follows the three-bit mode encoding
  typedef enum logic [2:0] {SMRL_M_FX100, SMRL_M_GBIC, SMRL_M_AUTO_SM, SMRL_M_AUTO_X,
                            SMRL_M_RSVD, SMRL_M_CU, SMRL_M_SM, SMRL_M_X} smrl_mode_t;
  typedef enum logic [2:0] {SMRL_MED_NONE, SMRL_MED_CU, SMRL_MED_X, SMRL_MED_SM, SMRL_MED_FX} smrl_media_t;
  typedef enum logic [2:0] {SMRL_CT_NORMAL, SMRL_CT_FLP, SMRL_CT_LINK_PULSE, SMRL_CT_IDLE100,
                            SMRL_CT_IDLE1000} smrl_cutx_t;
  typedef enum logic [1:0] {SMRL_FAN_STD, SMRL_FAN_MAC_ROLE, SMRL_FAN_OFF} smrl_fan_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } smrl_byte_t;
  typedef struct packed {
    logic       cu_link;
    logic [1:0] cu_speed;
    logic       cu_fd;
    logic       cu_an_done;
    logic [3:0] cu_partner;
    logic       x_link;
    logic       sm_link;
    logic [1:0] sm_speed;
    logic       sm_fd;
    logic       fx_link;
    logic       fib_sync;
    logic [3:0] mac_abil;
  } smrl_stat_t;
endpackage : smrl_pkg

/* verif/smrl_ctrl_assertions.sv */
// ****************************************
// port checker
// ****************************************
`include "smrl_cfg.svh"
module smrl_ctrl_chk
  import smrl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire smrl_byte_t  mac_rx,
  input wire smrl_byte_t  media_rx,
  input wire smrl_byte_t  mac_tx,
  input wire smrl_byte_t  media_tx,
  input wire logic        media_rx_ready,
  input wire logic        cu_rx_pwrdn,
  input wire smrl_cutx_t  cu_tx_kind,
  input wire logic        fib_pwr_up,
  input wire logic        fib_tx_idle,
  input wire logic [1:0]  host_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic loop;
  logic loop_q;
  // first loop cycle skipped: outputs may settle one edge apart
  assign loop = cu_rx_pwrdn | fib_tx_idle;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      loop_q <= 1'b0;
    end else begin
      loop_q <= loop;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_rd_wait;
    hready && hsel && htrans[1] && !hwrite && ce |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read data phase not one wait cycle");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_loop_media;
    loop_q && loop |-> !media_tx.valid && !media_rx_ready;
  endproperty
  a_loop_media: assert property (p_loop_media) else $error("media active in host loop");
  property p_loop_echo;
    loop_q && loop && $past(mac_rx.valid) |-> mac_tx == $past(mac_rx);
  endproperty
  a_loop_echo: assert property (p_loop_echo) else $error("loop echo wrong");
  property p_cu_kind;
    cu_rx_pwrdn && $past(cu_rx_pwrdn) |-> cu_tx_kind != SMRL_CT_NORMAL;
  endproperty
  a_cu_kind: assert property (p_cu_kind) else $error("copper sends data in loop");
  property p_fib_pwr;
    fib_tx_idle |-> fib_pwr_up;
  endproperty
  a_fib_pwr: assert property (p_fib_pwr) else $error("fiber off in loop");
  property p_rep100;
    media_rx.valid && media_rx_ready && ce && !loop && host_speed == `SMRL_SPD_100 |=>
      (mac_tx == {1'b1, $past(media_rx.data)}) && !media_rx_ready ##1 ($stable(mac_tx) && !media_rx_ready)[*8]
      ##1 media_rx_ready;
  endproperty
  a_rep100: assert property (p_rep100) else $error("byte not repeated ten times");
  property p_rep1000;
    media_rx.valid && media_rx_ready && ce && !loop && host_speed == `SMRL_SPD_1000 |=>
      media_rx_ready && mac_tx == {1'b1, $past(media_rx.data)};
  endproperty
  a_rep1000: assert property (p_rep1000) else $error("gigabit byte replicated");
endmodule : smrl_ctrl_chk
bind smrl_ctrl smrl_ctrl_chk i_chk (.*);

/* verif/smrl_mac_model.sv */
// ****************************************
// mac side model
// ****************************************
module smrl_mac_model
  import smrl_pkg::*;
(
  input wire logic   sys_clk,
  input wire logic   srst,
  input wire smrl_byte_t mac_tx,
  output smrl_byte_t mac_rx,
  output int unsigned rx_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial mac_rx = '0;
  always @(posedge sys_clk) begin
    if (srst) begin
      rx_cnt <= 0;
    end else if (mac_tx.valid === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
    end
  end
  // no serial-link negotiation is ever attempted here
  task send(input logic [7:0] d, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      mac_rx <= {1'b1, d}; // rate-adapted copies
    end
    @(posedge sys_clk);
    mac_rx <= {1'b0, ~d};
  endtask : send
endmodule : smrl_mac_model

/* verif/tb_smrl_ctrl.sv */
`include "smrl_cfg.svh"
// ****************************************
// register and stream tests
// ****************************************
module tb_smrl_ctrl
  import smrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, srst = 1, ce = 1, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0, media_strap = 2'h3, host_speed;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, media_rx_ready, cu_rx_pwrdn, fib_pwr_up, fib_tx_idle, fib_sync_rpt;
  logic        lineloop_cu, lineloop_fb, host_an_std, host_an_on;
  logic [15:0] host_cfg_word;
  logic [3:0]  cu_adv_eff;
  smrl_stat_t  stat = '0;
  smrl_byte_t  mac_rx, media_rx = '0, mac_tx, media_tx;
  smrl_cutx_t  cu_tx_kind;
  smrl_fan_t   fib_an_kind;
  int unsigned mac_cnt;
  int          errors = 0, cmp_count = 0, med_cnt = 0, n0, m0, i;
  logic [2:0]  med_exp [8] = '{3'h4, 3'h0, 3'h3, 3'h2, 3'h0, 3'h0, 3'h3, 3'h2};
  logic [1:0]  spd [3] = '{`SMRL_SPD_1000, `SMRL_SPD_100, `SMRL_SPD_10};
  int          rep [3] = '{1, 10, 100};
  assign hready = hreadyout;
  smrl_ctrl i_dut (.*);
  smrl_mac_model i_mac (.sys_clk(sys_clk), .srst(srst), .mac_tx(mac_tx), .mac_rx(mac_rx), .rx_cnt(mac_cnt));
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (media_tx.valid === 1'b1)
      med_cnt <= med_cnt + 1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // settle: status outputs follow the stored field one edge later
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge sys_clk);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task med(input logic [7:0] d);
    @(posedge sys_clk);
    media_rx <= {1'b1, d};
    do @(posedge sys_clk); while (media_rx_ready !== 1'b1);
    media_rx <= {1'b0, ~d};
  endtask : med
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    i = 0;
    do begin
      bus(1'b0, `SMRL_OFF_STAT, 32'h0);
      i++;
    end while (rd[9] !== 1'b1 && i < 50);
    chk(rd[2:0], 3'h3);
    stat.x_link <= 1'b1; stat.sm_link <= 1'b1; stat.fx_link <= 1'b1;
    for (i = 0; i < 8; i++) begin
      wr(`SMRL_OFF_MODE, i);
      bus(1'b0, `SMRL_OFF_STAT, 32'h0);
      chk(rd[5:3], med_exp[i]);
      if (i == 0) chk(host_speed, `SMRL_SPD_100);
      if (i == 6) chk(fib_an_kind, SMRL_FAN_MAC_ROLE);
      if (i == 6) chk(host_speed, `SMRL_SPD_10);
      if (i == 7) chk(fib_an_kind, SMRL_FAN_STD);
    end
    $display("mode test done");
    wr(`SMRL_OFF_MODE, 32'h5);
    stat.cu_link <= 1'b1; stat.cu_fd <= 1'b1;
    for (i = 0; i < 3; i++) begin
      stat.cu_speed <= spd[i];
      repeat (3) @(posedge sys_clk);
      n0 = mac_cnt;
      med(8'ha5 + i);
      repeat (110) @(posedge sys_clk);
      chk(mac_cnt - n0, rep[i]);
    end
    chk(host_cfg_word & 16'h9c01, 16'h9001);
    stat.cu_speed <= `SMRL_SPD_100;
    m0 = med_cnt;
    i_mac.send(8'h3c, 10);
    repeat (5) @(posedge sys_clk);
    chk(med_cnt - m0, 1);
    $display("rate test done");
    wr(`SMRL_OFF_HOST, 32'h2000);
    chk(host_an_on, 1'b0);
    wr(`SMRL_OFF_CU, 32'h5000);
    rdc(`SMRL_OFF_FB, 32'h4000 | 32'h1040);
    chk(cu_rx_pwrdn, 1'b1);
    chk(cu_tx_kind, SMRL_CT_FLP);
    chk(host_speed, `SMRL_SPD_100);
    n0 = mac_cnt;
    m0 = med_cnt;
    i_mac.send(8'h77, 4);
    repeat (4) @(posedge sys_clk);
    chk(mac_cnt - n0, 4);
    chk(med_cnt - m0, 0);
    wr(`SMRL_OFF_CU, 32'h4000);
    chk(cu_tx_kind, SMRL_CT_LINK_PULSE);
    wr(`SMRL_OFF_CU, 32'h6000);
    chk(cu_tx_kind, SMRL_CT_IDLE100);
    wr(`SMRL_OFF_FB, 32'h0);
    rdc(`SMRL_OFF_CU, 32'h2000);
    wr(`SMRL_OFF_MODE, 32'h7);
    stat.fib_sync <= 1'b1;
    wr(`SMRL_OFF_FB, 32'h4000);
    chk({fib_tx_idle, fib_pwr_up, fib_sync_rpt}, 3'h7);
    wr(`SMRL_OFF_FB, 32'h0);
    $display("loop test done");
    wr(`SMRL_OFF_MODE, 32'h5);
    wr(`SMRL_OFF_HOST, 32'h4040);
    chk({lineloop_cu, lineloop_fb}, 2'h2);
    wr(`SMRL_OFF_HOST, 32'h0040);
    stat.mac_abil <= 4'h1; stat.cu_an_done <= 1'b1; stat.cu_partner <= 4'h5; stat.cu_speed <= `SMRL_SPD_1000;
    wr(`SMRL_OFF_MODE, 32'h1);
    chk(cu_adv_eff, 4'h1);
    rdc(`SMRL_OFF_ADV, 32'hf);
    chk(host_cfg_word[8:5], 4'h5);
    chk(host_an_std, 1'b1);
    chk(host_speed, `SMRL_SPD_1000);
    rdc(8'h40, 32'h0);
    $display("converter test done");
    finish_test();
  end
endmodule : tb_smrl_ctrl
